// >>> rtl/pmx_pkg.sv
// pmx_pkg: register map, reset values and carrier types for the port 3..6 pin mux
// assumes a 32-bit apb slave with byte addresses, one register per aligned word
package pmx_pkg;
  localparam int AW = 7;
  // register byte offsets
  localparam logic [AW-1:0] ADR_P3_LAT  = 7'h00;
  localparam logic [AW-1:0] ADR_P3_DIR  = 7'h04;
  localparam logic [AW-1:0] ADR_P3_FUNC = 7'h08;
  localparam logic [AW-1:0] ADR_P4_LAT  = 7'h0C;
  localparam logic [AW-1:0] ADR_P4_DIR  = 7'h10;
  localparam logic [AW-1:0] ADR_P5_LAT  = 7'h14;
  localparam logic [AW-1:0] ADR_P5_DIR  = 7'h18;
  localparam logic [AW-1:0] ADR_P6_LAT  = 7'h1C;
  localparam logic [AW-1:0] ADR_P6_DIR  = 7'h20;
  localparam logic [AW-1:0] ADR_MEM_EXT = 7'h24;
  localparam logic [AW-1:0] ADR_WAIT_A  = 7'h28;
  localparam logic [AW-1:0] ADR_WAIT_B  = 7'h2C;
  localparam logic [AW-1:0] ADR_HOLD    = 7'h30;
  localparam logic [AW-1:0] ADR_RFSH    = 7'h34;
  localparam logic [AW-1:0] ADR_IRQ_EDG = 7'h38;
  localparam logic [AW-1:0] ADR_PINS    = 7'h3C;
  localparam logic [AW-1:0] ADR_P2_PINS = 7'h40;
  // reset values: direction 1 means input
  localparam logic [7:0]  DIR_RST  = 8'hFF;
  localparam logic [7:0]  LAT_RST  = 8'h00;
  localparam logic [3:0]  MEM_RST  = 4'h0;
  // field positions and codes
  localparam int          HOLD_EN_BIT = 7;
  localparam int          RFSH_EN_BIT = 7;
  localparam logic [1:0]  WAIT_EXT    = 2'h3;
  localparam logic [3:0]  MID_BASE    = 4'h2;
  localparam logic [3:0]  UP_BASE     = 4'h6;

  // one port's pin drive: oe_n low means the pin is driven
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pmx_pin_s;

  // from the bus controller
  typedef struct packed {
    logic [7:0] ad_out;
    logic       ad_oe;
    logic [7:0] addr_mid;
    logic [3:0] addr_up;
    logic       rd_n;
    logic       wr_n;
    logic       hold_ack;
    logic       refresh;
  } pmx_bus_s;

  // from the serial units and timers
  typedef struct packed {
    logic       txd;
    logic       csi0_clk_out;
    logic       csi0_clk_oe;
    logic       csi0_dout;
    logic       iic_mode;
    logic       scl_low;
    logic       sda_low;
    logic [3:0] timer_out;
  } pmx_ser_s;

  // pin levels handed to the peripherals
  typedef struct packed {
    logic       rxd;
    logic       csi0_clk_in;
    logic       sda_in;
    logic       baud_clk;
    logic       csi0_din;
    logic [7:0] ad_in;
    logic       wait_in;
    logic       hold_req;
  } pmx_fb_s;

  // edge events from the interrupt pins
  typedef struct packed {
    logic [5:0] irq;
    logic       t1_trig;
    logic       t2_cap_b;
    logic       t2_clk_cap_a;
    logic       t0_trig;
    logic       adc_trig;
  } pmx_trig_s;

  typedef struct packed {
    logic [7:0]  p3_lat, p3_dir, p3_func;
    logic [7:0]  p4_lat, p4_dir, p5_lat, p5_dir, p6_lat, p6_dir;
    logic [3:0]  mem_ext;
    logic [15:0] wait_a, wait_b;
    logic [7:0]  hold_mode, rfsh_mode;
    logic [11:0] irq_edge;
    logic [5:0]  p2_prev;
    logic        pready, pslverr;
    logic [31:0] prdata;
    pmx_pin_s    p3, p4, p5, p6;
    pmx_fb_s     fb;
    pmx_trig_s   trig;
  } pmx_state_s;
endpackage

// >>> rtl/pmx_port_mux.sv
// pmx_port_mux: port 3..6 pin multiplexer with apb register file and port 2 edge events
// assumes pins resolved outside from out/oe_n, inputs synchronous to pclk
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (RULE_01) port 3 function bit: 0 port, 1 alternate
// (RULE_02) port 3 port pins follow direction bits
// (RULE_03) port 3 pin levels always readable
// (RULE_04) reset: port 3 inputs, high impedance
// (RULE_05) port 3 alternate serial and timer pins
// (RULE_06) two-wire variant: pins 2,3 SCL/SDA
// (RULE_07) port 4 becomes address/data bus
// (RULE_08) reset: port 4 inputs, high impedance
// (RULE_09) port 5 address 8..15 in pairs
// (RULE_10) reset: port 5 inputs, high impedance
// (RULE_11) full variant: port 6 plain, reset inputs
// (RULE_12) port 6 pins 0..3 upper address pairs
// (RULE_13) port 6 pins 4,5 read/write strobes
// (RULE_14) port 6 pin 6 external wait input
// (RULE_15) hold enable: request in, acknowledge out
// (RULE_16) refresh enable drives pin 7 pulses
// (RULE_17) reduced variant: fixed port 6 roles
// (RULE_18) reduced variant: port 6 reset levels
// (RULE_19) reduced variant: latch low nibble zero
// (RULE_20) reduced variant: ports 4,5 always bus
// (RULE_21) interrupt pins raise request on edge
// (RULE_22) interrupt pins also feed triggers
// (RULE_23) alternate pins ignore latch and direction
module pmx_port_mux #(
  parameter bit REDUCED = 1'b0,
  parameter bit HAS_IIC = 1'b1
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [6:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pin levels
  input  wire logic [7:0]            p2_in,
  input  wire logic [7:0]            p3_in,
  input  wire logic [7:0]            p4_in,
  input  wire logic [7:0]            p5_in,
  input  wire logic [7:0]            p6_in,
  // pin drive
  output pmx_pkg::pmx_pin_s          p3_pin,
  output pmx_pkg::pmx_pin_s          p4_pin,
  output pmx_pkg::pmx_pin_s          p5_pin,
  output pmx_pkg::pmx_pin_s          p6_pin,
  // peripheral side
  input  wire pmx_pkg::pmx_bus_s     bus,
  input  wire pmx_pkg::pmx_ser_s     ser,
  output pmx_pkg::pmx_fb_s           fb,
  output pmx_pkg::pmx_trig_s         trig
);
  import pmx_pkg::*;

  pmx_state_s s;
  pmx_state_s next_s;

  // alternate pins take the function's drive, others the latch and direction
  function automatic pmx_pin_s mux8(input logic [7:0] alt, input logic [7:0] a_out,
                                    input logic [7:0] a_oe_n, input logic [7:0] lat,
                                    input logic [7:0] dir);
    pmx_pin_s r;
    r.out  = (alt & a_out) | (~alt & lat);
    r.oe_n = (alt & a_oe_n) | (~alt & dir);
    return r;
  endfunction

  logic       ext_on;
  logic [3:0] mid_on;
  logic [1:0] up_on;
  logic       hold_en;
  logic       rfsh_en;
  logic       wait_sel;
  logic [31:0] wait_all;
  logic [5:0] edge_hit;
  logic [7:0] p3_aout;
  logic [7:0] p3_aoe_n;
  logic [7:0] p6_alt;
  logic [7:0] p6_aout;
  logic [7:0] p6_aoe_n;

  // pin role decode, shared by the pin drive and the assertions
  always_comb begin
    ext_on   = REDUCED || (s.mem_ext != 4'h0);                          // RULE_13 RULE_20
    for (int k = 0; k < 4; k++) begin
      mid_on[k] = REDUCED || (s.mem_ext >= MID_BASE + 4'(k));          // RULE_09 RULE_20
    end
    for (int j = 0; j < 2; j++) begin
      up_on[j] = s.mem_ext >= UP_BASE + 4'(j);                          // RULE_12
    end
    hold_en  = s.hold_mode[HOLD_EN_BIT];
    rfsh_en  = s.rfsh_mode[RFSH_EN_BIT];
    // eight two-bit area fields, area n at bits 2n+1:2n of the joined word
    wait_all = {s.wait_b, s.wait_a};
    wait_sel = 1'b0;
    for (int a = 0; a < 8; a++) begin
      if (wait_all[2*a +: 2] == WAIT_EXT) begin
        wait_sel = 1'b1;
      end
    end
    wait_sel = wait_sel && s.p6_dir[6];                                 // RULE_14
    edge_hit = (p2_in[5:0] & ~s.p2_prev & s.irq_edge[5:0])
             | (~p2_in[5:0] & s.p2_prev & s.irq_edge[11:6]);           // RULE_21
  end

  // alternate drive for ports 3 and 6
  always_comb begin
    // receive pin is input only; two-wire mode pulls low, never drives high
    p3_aout  = {ser.timer_out, ser.csi0_dout, ser.csi0_clk_out, ser.txd, 1'b1}; // RULE_05
    p3_aoe_n = {4'h0, 1'b0, ~ser.csi0_clk_oe, 1'b0, 1'b1};
    if (HAS_IIC && ser.iic_mode) begin
      p3_aout[3:2]  = 2'b00;                                            // RULE_06
      p3_aoe_n[3:2] = ~{ser.sda_low, ser.scl_low};
    end
    // hold takes pin 7 before refresh; pin 6 is then an input
    p6_alt   = {hold_en | rfsh_en, hold_en, {2{ext_on}}, {2{up_on[1]}}, {2{up_on[0]}}};
    p6_aout  = {hold_en ? bus.hold_ack : bus.refresh, 1'b1, bus.wr_n, bus.rd_n,
                bus.addr_up};                                           // RULE_15 RULE_16
    p6_aoe_n = {1'b0, 1'b1, 2'b00, 4'h0};
    if (REDUCED) begin
      p6_alt[5:4] = 2'b11;                                              // RULE_17
    end
  end

  // register file, pin drive and event capture
  always_comb begin
    logic [31:0] rd;
    logic        hit;
    rd             = 32'h0;
    hit            = 1'b1;
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    // setup cycle: decode and load read data, answer in the access cycle
    if (psel && !penable && !s.pready) begin
      if (paddr == ADR_P3_LAT) begin
        rd = {24'h0, s.p3_lat};
      end else if (paddr == ADR_P3_DIR) begin
        rd = {24'h0, s.p3_dir};
      end else if (paddr == ADR_P3_FUNC) begin
        rd = {24'h0, s.p3_func};
      end else if (paddr == ADR_P4_LAT) begin
        rd = {24'h0, s.p4_lat};
      end else if (paddr == ADR_P4_DIR) begin
        rd = {24'h0, s.p4_dir};
      end else if (paddr == ADR_P5_LAT) begin
        rd = {24'h0, s.p5_lat};
      end else if (paddr == ADR_P5_DIR) begin
        rd = {24'h0, s.p5_dir};
      end else if (paddr == ADR_P6_LAT) begin
        rd = {24'h0, s.p6_lat};
      end else if (paddr == ADR_P6_DIR) begin
        rd = {24'h0, s.p6_dir};
      end else if (paddr == ADR_MEM_EXT) begin
        rd = {28'h0, s.mem_ext};
      end else if (paddr == ADR_WAIT_A) begin
        rd = {16'h0, s.wait_a};
      end else if (paddr == ADR_WAIT_B) begin
        rd = {16'h0, s.wait_b};
      end else if (paddr == ADR_HOLD) begin
        rd = {24'h0, s.hold_mode};
      end else if (paddr == ADR_RFSH) begin
        rd = {24'h0, s.rfsh_mode};
      end else if (paddr == ADR_IRQ_EDG) begin
        rd = {20'h0, s.irq_edge};
      end else if (paddr == ADR_PINS) begin
        rd = {p6_in, p5_in, p4_in, p3_in};                              // RULE_03
      end else if (paddr == ADR_P2_PINS) begin
        rd = {24'h0, p2_in};
      end else begin
        hit = 1'b0;
      end
      next_s.pready  = 1'b1;
      next_s.prdata  = rd;
      next_s.pslverr = !hit;
    end
    // access cycle: writes land here; pin level registers ignore writes
    if (psel && penable && s.pready && pwrite && !s.pslverr) begin
      if (paddr == ADR_P3_LAT) begin
        next_s.p3_lat = pwdata[7:0];
      end else if (paddr == ADR_P3_DIR) begin
        next_s.p3_dir = pwdata[7:0];
      end else if (paddr == ADR_P3_FUNC) begin
        next_s.p3_func = pwdata[7:0];
      end else if (paddr == ADR_P4_LAT) begin
        next_s.p4_lat = pwdata[7:0];
      end else if (paddr == ADR_P4_DIR) begin
        next_s.p4_dir = pwdata[7:0];
      end else if (paddr == ADR_P5_LAT) begin
        next_s.p5_lat = pwdata[7:0];
      end else if (paddr == ADR_P5_DIR) begin
        next_s.p5_dir = pwdata[7:0];
      end else if (paddr == ADR_P6_LAT) begin
        next_s.p6_lat = pwdata[7:0];
      end else if (paddr == ADR_P6_DIR) begin
        next_s.p6_dir = pwdata[7:0];
      end else if (paddr == ADR_MEM_EXT) begin
        next_s.mem_ext = pwdata[3:0];
      end else if (paddr == ADR_WAIT_A) begin
        next_s.wait_a = pwdata[15:0];
      end else if (paddr == ADR_WAIT_B) begin
        next_s.wait_b = pwdata[15:0];
      end else if (paddr == ADR_HOLD) begin
        next_s.hold_mode = pwdata[7:0];
      end else if (paddr == ADR_RFSH) begin
        next_s.rfsh_mode = pwdata[7:0];
      end else if (paddr == ADR_IRQ_EDG) begin
        next_s.irq_edge = pwdata[11:0];
      end
    end
    // pin drive, one flop stage so every output is registered
    next_s.p3 = mux8(s.p3_func, p3_aout, p3_aoe_n, s.p3_lat, s.p3_dir); // RULE_01 RULE_02 RULE_23
    next_s.p4 = mux8({8{ext_on}}, bus.ad_out, {8{~bus.ad_oe}}, s.p4_lat, s.p4_dir); // RULE_07
    next_s.p5 = mux8({{2{mid_on[3]}}, {2{mid_on[2]}}, {2{mid_on[1]}}, {2{mid_on[0]}}},
                     bus.addr_mid, 8'h00, s.p5_lat, s.p5_dir);          // RULE_09
    next_s.p6 = mux8(p6_alt, p6_aout, p6_aoe_n, s.p6_lat, s.p6_dir);    // RULE_11 RULE_23
    if (REDUCED) begin
      next_s.p6.oe_n[3:0] = 4'h0;                                       // RULE_17 RULE_18
    end
    // port 3 alternate inputs reach a unit only while the pin is assigned to it; port 2 and port 4 levels pass ungated
    next_s.fb.rxd         = s.p3_func[0] ? p3_in[0] : 1'b1;
    next_s.fb.csi0_clk_in = s.p3_func[2] ? p3_in[2] : 1'b1;
    next_s.fb.sda_in      = s.p3_func[3] ? p3_in[3] : 1'b1;
    next_s.fb.baud_clk    = p2_in[4];
    next_s.fb.csi0_din    = p2_in[7];
    next_s.fb.ad_in       = p4_in;
    next_s.fb.wait_in     = wait_sel && p6_in[6];                       // RULE_14
    next_s.fb.hold_req    = hold_en && p6_in[6];                        // RULE_15
    // interrupt and trigger events, one-cycle pulses
    next_s.p2_prev           = p2_in[5:0];
    next_s.trig.irq          = edge_hit;                                // RULE_21
    next_s.trig.t1_trig      = edge_hit[0];                             // RULE_22
    next_s.trig.t2_cap_b     = edge_hit[1];
    next_s.trig.t2_clk_cap_a = edge_hit[2];
    next_s.trig.t0_trig      = edge_hit[3];
    next_s.trig.adc_trig     = edge_hit[5];
  end

  // reset leaves every port pin floating except the reduced strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.p3_dir    <= DIR_RST;                                           // RULE_04
      s.p4_dir    <= DIR_RST;                                           // RULE_08
      s.p5_dir    <= DIR_RST;                                           // RULE_10
      s.p6_dir    <= DIR_RST;                                           // RULE_11
      s.p3_lat    <= LAT_RST;
      s.p4_lat    <= LAT_RST;
      s.p5_lat    <= LAT_RST;
      s.p6_lat    <= LAT_RST;                                           // RULE_19
      s.mem_ext   <= MEM_RST;
      s.p3.oe_n   <= 8'hFF;
      s.p4.oe_n   <= 8'hFF;
      s.p5.oe_n   <= 8'hFF;
      s.p6.oe_n   <= REDUCED ? 8'hCF : 8'hFF;                           // RULE_18
      s.p6.out    <= REDUCED ? 8'h30 : 8'h00;
      s.fb.rxd    <= 1'b1;
      s.fb.csi0_clk_in <= 1'b1;
      s.fb.sda_in <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign p3_pin  = s.p3;
  assign p4_pin  = s.p4;
  assign p5_pin  = s.p5;
  assign p6_pin  = s.p6;
  assign fb      = s.fb;
  assign trig    = s.trig;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_rise0;
    !p2_in[0] ##1 p2_in[0];
  endsequence

  property p_apb_answer;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

  property p_p3_port;
    (s.p3_func == 8'h00) |=> (p3_pin.oe_n == $past(s.p3_dir)) && (p3_pin.out == $past(s.p3_lat));
  endproperty
  a_p3_port: assert property (p_p3_port) else $error("port 3 port mode drive wrong"); // RULE_02

  property p_pin_read;
    (s_setup ##0 paddr == ADR_PINS) |=> prdata[7:0] == $past(p3_in);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("port 3 level read wrong"); // RULE_03

  property p_timer_out;
    (s.p3_func[7:4] == 4'hF) |=> p3_pin.out[7:4] == $past(ser.timer_out) && p3_pin.oe_n[7:4] == 4'h0;
  endproperty
  a_timer_out: assert property (p_timer_out) else $error("timer outputs not routed"); // RULE_05

  property p_ad_bus;
    ext_on |=> p4_pin.out == $past(bus.ad_out) && p4_pin.oe_n == {8{!$past(bus.ad_oe)}};
  endproperty
  a_ad_bus: assert property (p_ad_bus) else $error("address/data bus not routed"); // RULE_07

  property p_mid_addr;
    (s.mem_ext >= 4'h5) |=> p5_pin.out == $past(bus.addr_mid) && p5_pin.oe_n == 8'h00;
  endproperty
  a_mid_addr: assert property (p_mid_addr) else $error("middle address not routed"); // RULE_09

  property p_strobes;
    ext_on |=> p6_pin.out[5:4] == $past({bus.wr_n, bus.rd_n}) && p6_pin.oe_n[5:4] == 2'b00;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes not routed"); // RULE_13

  property p_wait;
    fb.wait_in |-> $past(wait_sel) && $past(p6_in[6]);
  endproperty
  a_wait: assert property (p_wait) else $error("wait input without selection"); // RULE_14

  property p_wait_area;
    (s.wait_a[1:0] == WAIT_EXT && s.p6_dir[6] && p6_in[6]) |=> fb.wait_in;
  endproperty
  a_wait_area: assert property (p_wait_area) else $error("area 0 external wait lost"); // RULE_14

  property p_hold;
    hold_en |=> fb.hold_req == $past(p6_in[6]) && p6_pin.out[7] == $past(bus.hold_ack);
  endproperty
  a_hold: assert property (p_hold) else $error("bus hold pins wrong"); // RULE_15

  property p_edge;
    (s_rise0 ##0 s.irq_edge[0]) |=> trig.irq[0] && trig.t1_trig ##1 !trig.irq[0];
  endproperty
  a_edge: assert property (p_edge) else $error("pin 0 rising edge lost"); // RULE_21
endmodule

`default_nettype wire

// >>> testbench/pmx_far_side.sv
// pmx_far_side: pads and outside world of ports 3..6
// assumes the bench chooses what the outside drives; undriven lines rest at the pull-up
`timescale 1ns/1ns
`default_nettype none
module pmx_far_side
  import pmx_pkg::*;
(
  // pin drive from the mux
  input  wire pmx_pkg::pmx_pin_s p3_pin,
  input  wire pmx_pkg::pmx_pin_s p4_pin,
  input  wire pmx_pkg::pmx_pin_s p5_pin,
  input  wire pmx_pkg::pmx_pin_s p6_pin,
  // outside drive, bit 8p+n is port p+3 pin n
  input  wire logic [31:0]       ext_val,
  input  wire logic [31:0]       ext_en,
  // resolved pin levels
  output logic      [31:0]       lvl
);
  logic [31:0] drv;
  logic [31:0] oe_n;

  // contention is not modelled: a driven pin shows the device's level
  assign drv  = {p6_pin.out, p5_pin.out, p4_pin.out, p3_pin.out};
  assign oe_n = {p6_pin.oe_n, p5_pin.oe_n, p4_pin.oe_n, p3_pin.oe_n};
  // a released pin never keeps its old value, it takes the outside drive or the pull-up
  assign lvl  = (drv & ~oe_n) | (ext_val & ext_en & oe_n) | (~ext_en & oe_n);
endmodule
`default_nettype wire

// >>> testbench/test_pmx_port_mux.sv
// test_pmx_port_mux: register, pin and edge checks of the port 3..6 mux, full variant
// assumes one 50 MHz clock; the far side model resolves every port 3..6 pin level
`timescale 1ns/1ns
`default_nettype none
module test_pmx_port_mux;
  import pmx_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [6:0]  paddr;
  logic [31:0] pwdata, prdata, lvl, ext_val, ext_en, rd;
  logic [7:0]  p2_in, m5, m6;
  pmx_pin_s    p3_pin, p4_pin, p5_pin, p6_pin;
  pmx_bus_s    bus;
  pmx_ser_s    ser;
  pmx_fb_s     fb;
  pmx_trig_s   trig;
  int          num_errors, check_count, cycles;
  // extra trigger bits raised with each interrupt pin
  logic [4:0]  side_tbl [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h00, 5'h01};

  // clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  pmx_port_mux #(.REDUCED(1'b0), .HAS_IIC(1'b1)) pmx_port_mux_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p2_in(p2_in), .p3_in(lvl[7:0]), .p4_in(lvl[15:8]), .p5_in(lvl[23:16]),
    .p6_in(lvl[31:24]), .p3_pin(p3_pin), .p4_pin(p4_pin), .p5_pin(p5_pin),
    .p6_pin(p6_pin), .bus(bus), .ser(ser), .fb(fb), .trig(trig));

  pmx_far_side pmx_far_side_inst (
    .p3_pin(p3_pin), .p4_pin(p4_pin), .p5_pin(p5_pin), .p6_pin(p6_pin),
    .ext_val(ext_val), .ext_en(ext_en), .lvl(lvl));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is judged at the rising edge itself; the hang guard ends a lost answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pins are registered behind the registers, so allow three edges
  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 7'h00;
    pwdata = 32'h0;
    p2_in = 8'h00;
    bus = '0;
    ser = '0;
    ext_val = 32'h0;
    ext_en = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check({p6_pin.oe_n, p5_pin.oe_n, p4_pin.oe_n, p3_pin.oe_n}, 32'hFFFFFFFF, "float");
    apb(1'b0, ADR_P3_DIR, 32'h0);
    check(rd, 32'hFF, "p3 dir");
    apb(1'b0, ADR_P6_DIR, 32'h0);
    check(rd, 32'hFF, "p6 dir");
    apb(1'b0, 7'h44, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    // port 3 as plain port: high nibble out, low nibble read from outside
    ext_val <= 32'h2;
    ext_en <= 32'hF;
    apb(1'b1, ADR_P3_LAT, 32'h5A);
    apb(1'b1, ADR_P3_DIR, 32'h0F);
    settle();
    check(p3_pin.oe_n, 8'h0F, "p3 dir drive");
    check(p3_pin.out & 8'hF0, 8'h50, "p3 latch");
    check(fb.rxd, 1'b1, "rxd unselected");
    apb(1'b0, ADR_PINS, 32'h0);
    check(rd, 32'hFFFFFF52, "pin levels");
    // alternate functions must win over latch and direction
    ser.timer_out <= 4'hA;
    ser.txd <= 1'b0;
    apb(1'b1, ADR_P3_DIR, 32'hFF);
    apb(1'b1, ADR_P3_FUNC, 32'hF3);
    settle();
    check(p3_pin.oe_n, 8'h0D, "p3 alt drive");
    check(p3_pin.out & 8'hF2, 8'hA0, "p3 alt out");
    check(fb.rxd, 1'b0, "rxd selected");
    apb(1'b0, ADR_PINS, 32'h0);
    check(rd[7:0], 8'hA0, "alt levels");
    // two-wire mode: pins only pull low, pin 3 floats and reads the outside low
    ser.iic_mode <= 1'b1;
    ser.scl_low <= 1'b1;
    apb(1'b1, ADR_P3_FUNC, 32'h0C);
    settle();
    check({p3_pin.oe_n[3:2], p3_pin.out[3:2], fb.sda_in}, 5'b10000, "two-wire drive");
    apb(1'b1, ADR_P3_FUNC, 32'h0);
    $display("test port3 done");
    // memory extension field walked through every code
    bus <= '{ad_out: 8'hC3, ad_oe: 1'b1, addr_mid: 8'h96, addr_up: 4'h9,
             rd_n: 1'b0, wr_n: 1'b1, hold_ack: 1'b1, refresh: 1'b0};
    for (int f = 0; f < 16; f++) begin
      m5 = 8'h00;
      m6 = (f >= 1) ? 8'h30 : 8'h00;
      for (int k = 0; k < 4; k++) if (f >= 2 + k) m5 = m5 | (8'h03 << (2 * k));
      for (int j = 0; j < 2; j++) if (f >= 6 + j) m6 = m6 | (8'h03 << (2 * j));
      apb(1'b1, ADR_MEM_EXT, 32'(f));
      settle();
      check({p4_pin.oe_n, p5_pin.oe_n, p6_pin.oe_n}, {(f >= 1) ? 8'h00 : 8'hFF, ~m5, ~m6},
            "ext drive");
    end
    check({p4_pin.out, p5_pin.out, p6_pin.out[5:0]}, 22'h30E5A9, "bus out");
    check(fb.ad_in, 8'hC3, "ad bus level back");
    @(posedge pclk);
    bus.ad_oe <= 1'b0;
    settle();
    check(p4_pin.oe_n, 8'hFF, "ad released");
    apb(1'b1, ADR_MEM_EXT, 32'h0);
    $display("test mem ext done");
    // port 6 pins 6 and 7: hold, refresh, wait
    ext_en <= 32'h40000000;
    ext_val <= 32'h0;
    apb(1'b1, ADR_HOLD, 32'h80);
    apb(1'b1, ADR_RFSH, 32'h80);
    settle();
    check({p6_pin.oe_n[7:6], p6_pin.out[7], fb.hold_req}, 4'b0110, "hold");
    apb(1'b1, ADR_HOLD, 32'h0);
    settle();
    check({p6_pin.oe_n[7], p6_pin.out[7]}, 2'b00, "refresh");
    apb(1'b1, ADR_WAIT_A, 32'h3);
    settle();
    check(fb.wait_in, 1'b0, "wait low");
    @(posedge pclk);
    ext_val <= 32'h40000000;
    settle();
    check(fb.wait_in, 1'b1, "wait high");
    $display("test port6 done");
    // rising edges enabled, falling edges refused
    apb(1'b1, ADR_IRQ_EDG, 32'h3F);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      p2_in[i] <= 1'b1;
      repeat (2) @(negedge pclk);
      check(trig, {6'b1 << i, side_tbl[i]}, "edge event");
      @(negedge pclk);
      check(trig, 11'h0, "event width");
      @(posedge pclk);
      p2_in[i] <= 1'b0;
      repeat (2) @(negedge pclk);
      check(trig, 11'h0, "falling off");
    end
    $display("test edges done");
    wrap_up();
  end
endmodule
`default_nettype wire
